// File: cbie_pkg.sv
//==========================================================================
// Operation
// - Three transmit-buffer enables in bits four to two
// - Unused transmit-enable bits read zero, ignore writes
// - Buffer enables act only in modes one, two
// - Transmit interrupt needs group transmit enable too
// - Six programmable-buffer enables in bits seven to two
// - Two receive-buffer enables in bits one, zero
// - Buffer interrupt needs matching group enable set
// - Unimplemented map addresses read as zero
// - Status register mirrored read-only at repeated addresses
// - Enhanced modes: combined transmit flag on completion
// - Enhanced modes: combined receive flag on reception
// - Enhanced modes: group transmit enable gates all transmit interrupts
// - Enhanced modes: group receive enable gates all receive-buffer interrupts
//==========================================================================
`default_nettype none

package cbie_pkg;

    //======================================================================
    // Widths
    localparam int unsigned ADDR_W = 14;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned IDX_W  = 12;
    localparam int unsigned REG_W  = 8;

    //======================================================================
    // Register indices, byte address is four times the index
    localparam logic [11:0] IDX_TX_BUF_EN    = 12'hDFC;
    localparam logic [11:0] IDX_BUF_EN_LOW   = 12'hDFA;
    localparam logic [11:0] IDX_CTRL_STATUS  = 12'hF6E;
    localparam logic [11:0] IDX_PERIPH_FLAGS = 12'h0F0;
    localparam logic [11:0] IDX_PERIPH_EN    = 12'h0F1;
    localparam logic [11:0] IDX_MODE_CTRL    = 12'h0F2;
    localparam int unsigned N_MIRROR = 10;
    localparam logic [11:0] IDX_STATUS_MIRROR [N_MIRROR] = '{
        12'hF5E, 12'hF4E, 12'hF3E, 12'hF2E, 12'hE7E,
        12'hE6E, 12'hE5E, 12'hE4E, 12'hE3E, 12'hE2E};

    //======================================================================
    // Field layout
    localparam logic [7:0] TX_EN_IMPL   = 8'h1C;
    localparam logic [7:0] BUF_EN_IMPL  = 8'hFF;
    localparam logic [7:0] FULL_IMPL    = 8'hFF;
    localparam int unsigned TX_EN_LSB   = 2;
    localparam int unsigned PROG_EN_LSB = 2;
    localparam int unsigned RX_EN_LSB   = 0;
    localparam int unsigned FLG_INVALID = 7;
    localparam int unsigned FLG_WAKE    = 6;
    localparam int unsigned FLG_ERROR   = 5;
    localparam int unsigned FLG_TX_GRP  = 4;
    localparam int unsigned FLG_TX1     = 3;
    localparam int unsigned FLG_TX0     = 2;
    localparam int unsigned FLG_RX_GRP  = 1;
    localparam int unsigned FLG_RX0_WM  = 0;
    localparam logic [7:0] MASK_LEGACY  = 8'hFF;
    localparam logic [7:0] MASK_ENH     = 8'hF2;
    localparam logic [7:0] MASK_FIFO    = 8'hF3;

    //======================================================================
    // Reset values and bus codes
    localparam logic [7:0] RST_REG  = 8'h00;
    localparam logic [1:0] RESP_OK  = 2'h0;

    typedef enum logic [1:0] {
        MODE_LEGACY = 2'b00,
        MODE_ENH    = 2'b01,
        MODE_FIFO   = 2'b10
    } cbie_mode_type;

endpackage : cbie_pkg

`default_nettype wire

// File: cbie_rw_reg.sv
`default_nettype none

module cbie_rw_reg #(
    parameter logic [7:0] IMPL = 8'hFF
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // Write port
    input  wire logic       we_in,
    input  wire logic [7:0] wdata_in,
    // Stored value
    output var  logic [7:0] q_out
);

    logic [7:0] val_q;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            val_q <= cbie_pkg::RST_REG;
        else if (we_in)
            val_q <= wdata_in & IMPL;
    end

    assign q_out = val_q & IMPL;

endmodule : cbie_rw_reg

`default_nettype wire

// File: cbie_top.sv
`default_nettype none

module cbie_top (
    // Clock and reset
    input  wire logic        CLK_SYS_IN,
    input  wire logic        RST_IN,
    // AXI4-Lite write address
    input  wire logic        AXI_AWVALID_IN,
    output var  logic        AXI_AWREADY_OUT,
    input  wire logic [13:0] AXI_AWADDR_IN,
    // AXI4-Lite write data
    input  wire logic        AXI_WVALID_IN,
    output var  logic        AXI_WREADY_OUT,
    input  wire logic [31:0] AXI_WDATA_IN,
    input  wire logic [3:0]  AXI_WSTRB_IN,
    // AXI4-Lite write response
    output var  logic        AXI_BVALID_OUT,
    input  wire logic        AXI_BREADY_IN,
    output var  logic [1:0]  AXI_BRESP_OUT,
    // AXI4-Lite read address
    input  wire logic        AXI_ARVALID_IN,
    output var  logic        AXI_ARREADY_OUT,
    input  wire logic [13:0] AXI_ARADDR_IN,
    // AXI4-Lite read data
    output var  logic        AXI_RVALID_OUT,
    input  wire logic        AXI_RREADY_IN,
    output var  logic [31:0] AXI_RDATA_OUT,
    output var  logic [1:0]  AXI_RRESP_OUT,
    // Buffer events from the controller core
    input  wire logic [2:0]  TX_DONE_IN,
    input  wire logic [5:0]  PROG_DONE_IN,
    input  wire logic [5:0]  PROG_IS_TX_IN,
    input  wire logic [1:0]  RX_DONE_IN,
    input  wire logic        FIFO_WM_IN,
    input  wire logic        INVALID_MSG_IN,
    input  wire logic        WAKE_IN,
    input  wire logic        BUS_ERROR_IN,
    // Controller status value
    input  wire logic [7:0]  CTRL_STATUS_IN,
    // Interrupt requests
    output var  logic        IRQ_OUT,
    output var  logic        TX_GROUP_REQ_OUT,
    output var  logic        RX_GROUP_REQ_OUT
);

    //======================================================================
    // Declarations
    logic        aw_held_q;
    logic        aw_held_d;
    logic        w_held_q;
    logic        w_held_d;
    logic [11:0] aw_idx_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        awready_q;
    logic        wready_q;
    logic        bvalid_q;
    logic        aw_hs;
    logic        w_hs;
    logic        wr_fire;
    logic        low_lane;
    logic        arready_q;
    logic        rvalid_q;
    logic        rvalid_d;
    logic [31:0] rdata_q;
    logic        rd_hs;
    logic [11:0] rd_idx;
    logic [7:0]  rd_byte;

    logic        we_tx_en;
    logic        we_buf_en;
    logic        we_periph_en;
    logic        we_flags;
    logic        we_mode;

    logic [7:0]  tx_buffer_irq_enables;
    logic [7:0]  buffer_irq_enables_low;
    logic [7:0]  periph_irq_enable_3;
    logic [7:0]  flags_q;
    logic [7:0]  flag_set;
    logic [7:0]  flag_clr;
    logic [7:0]  periph_irq_flags_3;
    logic [7:0]  eff_en;
    logic [7:0]  status_q;
    cbie_pkg::cbie_mode_type mode_q;
    logic        enhanced;

    logic [2:0]  tx_buf_hit;
    logic [5:0]  prog_hit;
    logic [1:0]  rx_buf_hit;
    logic        any_tx;
    logic        any_rx;
    logic        tx_req;
    logic        rx_req;
    logic        irq_any;
    logic        irq_q;
    logic        tx_req_q;
    logic        rx_req_q;

    //======================================================================
    // Decode helpers
    function automatic logic is_status_idx(input logic [11:0] idx);
        logic hit;
        hit = (idx == cbie_pkg::IDX_CTRL_STATUS);
        for (int i = 0; i < cbie_pkg::N_MIRROR; i++)
        begin
            if (idx == cbie_pkg::IDX_STATUS_MIRROR[i])
                hit = 1'b1;
        end
        return hit;
    endfunction : is_status_idx

    function automatic logic [7:0] mode_mask(
        input cbie_pkg::cbie_mode_type mode
    );
        logic [7:0] m;
        m = cbie_pkg::MASK_LEGACY;
        unique case (mode)
            cbie_pkg::MODE_LEGACY: m = cbie_pkg::MASK_LEGACY;
            cbie_pkg::MODE_ENH:    m = cbie_pkg::MASK_ENH;
            cbie_pkg::MODE_FIFO:   m = cbie_pkg::MASK_FIFO;
            default:               m = cbie_pkg::MASK_LEGACY;
        endcase
        return m;
    endfunction : mode_mask

    //======================================================================
    // Write channels, address and data taken in either order
    assign aw_hs    = AXI_AWVALID_IN & awready_q;
    assign w_hs     = AXI_WVALID_IN & wready_q;
    assign wr_fire  = aw_held_q & w_held_q & ~bvalid_q;
    assign low_lane = w_strb_q[0];

    assign aw_held_d = (aw_held_q | aw_hs) & ~wr_fire;
    assign w_held_d  = (w_held_q | w_hs) & ~wr_fire;

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
        begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
        end
        else
        begin
            aw_held_q <= aw_held_d;
            w_held_q  <= w_held_d;
            awready_q <= ~aw_held_d;
            wready_q  <= ~w_held_d;
        end
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
        begin
            aw_idx_q <= 12'h000;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end
        else
        begin
            if (aw_hs)
                aw_idx_q <= AXI_AWADDR_IN[13:2];
            if (w_hs)
            begin
                w_data_q <= AXI_WDATA_IN;
                w_strb_q <= AXI_WSTRB_IN;
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
            bvalid_q <= 1'b0;
        else if (wr_fire)
            bvalid_q <= 1'b1;
        else if (AXI_BREADY_IN)
            bvalid_q <= 1'b0;
    end

    //======================================================================
    // Write strobes per register, unmapped writes dropped
    assign we_tx_en     = wr_fire & low_lane &
                          (aw_idx_q == cbie_pkg::IDX_TX_BUF_EN);
    assign we_buf_en    = wr_fire & low_lane &
                          (aw_idx_q == cbie_pkg::IDX_BUF_EN_LOW);
    assign we_periph_en = wr_fire & low_lane &
                          (aw_idx_q == cbie_pkg::IDX_PERIPH_EN);
    assign we_flags     = wr_fire & low_lane &
                          (aw_idx_q == cbie_pkg::IDX_PERIPH_FLAGS);
    assign we_mode      = wr_fire & low_lane &
                          (aw_idx_q == cbie_pkg::IDX_MODE_CTRL);

    //======================================================================
    // Enable registers
    cbie_rw_reg #(
        .IMPL (cbie_pkg::TX_EN_IMPL)
    ) u_tx_en (
        .clk_in   (CLK_SYS_IN),
        .rst_in   (RST_IN),
        .we_in    (we_tx_en),
        .wdata_in (w_data_q[7:0]),
        .q_out    (tx_buffer_irq_enables)
    );

    cbie_rw_reg #(
        .IMPL (cbie_pkg::BUF_EN_IMPL)
    ) u_buf_en (
        .clk_in   (CLK_SYS_IN),
        .rst_in   (RST_IN),
        .we_in    (we_buf_en),
        .wdata_in (w_data_q[7:0]),
        .q_out    (buffer_irq_enables_low)
    );

    cbie_rw_reg #(
        .IMPL (cbie_pkg::FULL_IMPL)
    ) u_periph_en (
        .clk_in   (CLK_SYS_IN),
        .rst_in   (RST_IN),
        .we_in    (we_periph_en),
        .wdata_in (w_data_q[7:0]),
        .q_out    (periph_irq_enable_3)
    );

    //======================================================================
    // Operating mode, illegal code leaves mode unchanged
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
            mode_q <= cbie_pkg::MODE_LEGACY;
        else if (we_mode)
        begin
            unique case (w_data_q[1:0])
                2'h0:    mode_q <= cbie_pkg::MODE_LEGACY;
                2'h1:    mode_q <= cbie_pkg::MODE_ENH;
                2'h2:    mode_q <= cbie_pkg::MODE_FIFO;
                default: mode_q <= mode_q;
            endcase
        end
    end

    assign enhanced = (mode_q != cbie_pkg::MODE_LEGACY);

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
            status_q <= cbie_pkg::RST_REG;
        else
            status_q <= CTRL_STATUS_IN;
    end

    //======================================================================
    // Per-buffer qualification
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_tx
            assign tx_buf_hit[g] = TX_DONE_IN[g] &
                tx_buffer_irq_enables[cbie_pkg::TX_EN_LSB + g];
        end
        for (g = 0; g < 6; g++)
        begin : g_prog
            assign prog_hit[g] = PROG_DONE_IN[g] &
                buffer_irq_enables_low[cbie_pkg::PROG_EN_LSB + g];
        end
        for (g = 0; g < 2; g++)
        begin : g_rx
            assign rx_buf_hit[g] = RX_DONE_IN[g] &
                buffer_irq_enables_low[cbie_pkg::RX_EN_LSB + g];
        end
    endgenerate

    // OR over buffers of event and own enable
    assign any_tx = (|tx_buf_hit) | (|(prog_hit & PROG_IS_TX_IN));
    assign any_rx = (|rx_buf_hit) | (|(prog_hit & ~PROG_IS_TX_IN));

    //======================================================================
    // Flag set sources by mode
    always_comb
    begin
        flag_set = 8'h00;
        flag_set[cbie_pkg::FLG_INVALID] = INVALID_MSG_IN;
        flag_set[cbie_pkg::FLG_WAKE]    = WAKE_IN;
        flag_set[cbie_pkg::FLG_ERROR]   = BUS_ERROR_IN;
        if (enhanced)
        begin
            flag_set[cbie_pkg::FLG_TX_GRP] = any_tx;
            flag_set[cbie_pkg::FLG_RX_GRP] = any_rx;
            flag_set[cbie_pkg::FLG_RX0_WM] =
                (mode_q == cbie_pkg::MODE_FIFO) & FIFO_WM_IN;
        end
        else
        begin
            // Legacy mode ignores the buffer enable registers
            flag_set[cbie_pkg::FLG_TX_GRP] = TX_DONE_IN[2];
            flag_set[cbie_pkg::FLG_TX1]    = TX_DONE_IN[1];
            flag_set[cbie_pkg::FLG_TX0]    = TX_DONE_IN[0];
            flag_set[cbie_pkg::FLG_RX_GRP] = RX_DONE_IN[1];
            flag_set[cbie_pkg::FLG_RX0_WM] = RX_DONE_IN[0];
        end
    end

    assign flag_clr = we_flags ? w_data_q[7:0] : 8'h00;

    // Sticky flags, a set in the clearing cycle wins
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
            flags_q <= cbie_pkg::RST_REG;
        else
            flags_q <= (flags_q & ~flag_clr) | flag_set;
    end

    assign periph_irq_flags_3 = flags_q & mode_mask(mode_q);
    assign eff_en             = periph_irq_enable_3 & mode_mask(mode_q);

    //======================================================================
    // Group gating and interrupt output
    assign tx_req = enhanced ?
        (periph_irq_flags_3[cbie_pkg::FLG_TX_GRP] &
         eff_en[cbie_pkg::FLG_TX_GRP]) :
        (|(periph_irq_flags_3[4:2] & eff_en[4:2]));
    assign rx_req = enhanced ?
        (periph_irq_flags_3[cbie_pkg::FLG_RX_GRP] &
         eff_en[cbie_pkg::FLG_RX_GRP]) :
        (|(periph_irq_flags_3[1:0] & eff_en[1:0]));
    assign irq_any = |(periph_irq_flags_3 & eff_en);

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
        begin
            irq_q    <= 1'b0;
            tx_req_q <= 1'b0;
            rx_req_q <= 1'b0;
        end
        else
        begin
            irq_q    <= irq_any;
            tx_req_q <= tx_req;
            rx_req_q <= rx_req;
        end
    end

    //======================================================================
    // Read channel
    assign rd_hs    = AXI_ARVALID_IN & arready_q;
    assign rd_idx   = AXI_ARADDR_IN[13:2];
    assign rvalid_d = (rvalid_q & ~AXI_RREADY_IN) | rd_hs;

    always_comb
    begin
        rd_byte = 8'h00;
        if (is_status_idx(rd_idx))
            rd_byte = status_q;
        else if (rd_idx == cbie_pkg::IDX_TX_BUF_EN)
            rd_byte = tx_buffer_irq_enables;
        else if (rd_idx == cbie_pkg::IDX_BUF_EN_LOW)
            rd_byte = buffer_irq_enables_low;
        else if (rd_idx == cbie_pkg::IDX_PERIPH_EN)
            rd_byte = eff_en;
        else if (rd_idx == cbie_pkg::IDX_PERIPH_FLAGS)
            rd_byte = periph_irq_flags_3;
        else if (rd_idx == cbie_pkg::IDX_MODE_CTRL)
            rd_byte = {6'h00, mode_q};
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (RST_IN)
        begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b0;
            rdata_q   <= 32'h0000_0000;
        end
        else
        begin
            rvalid_q  <= rvalid_d;
            arready_q <= ~rvalid_d;
            if (rd_hs)
                rdata_q <= {24'h00_0000, rd_byte};
        end
    end

    //======================================================================
    // Outputs
    assign AXI_AWREADY_OUT  = awready_q;
    assign AXI_WREADY_OUT   = wready_q;
    assign AXI_BVALID_OUT   = bvalid_q;
    assign AXI_BRESP_OUT    = cbie_pkg::RESP_OK;
    assign AXI_ARREADY_OUT  = arready_q;
    assign AXI_RVALID_OUT   = rvalid_q;
    assign AXI_RDATA_OUT    = rdata_q;
    assign AXI_RRESP_OUT    = cbie_pkg::RESP_OK;
    assign IRQ_OUT          = irq_q;
    assign TX_GROUP_REQ_OUT = tx_req_q;
    assign RX_GROUP_REQ_OUT = rx_req_q;

endmodule : cbie_top

`default_nettype wire

// File: cbie_top_assertions.sv
`default_nettype none

module cbie_chk (
    // Clock and reset
    input wire logic        CLK_SYS_IN,
    input wire logic        RST_IN,
    // Register bus
    input wire logic        AXI_AWVALID_IN,
    input wire logic        AXI_AWREADY_OUT,
    input wire logic        AXI_WVALID_IN,
    input wire logic        AXI_WREADY_OUT,
    input wire logic        AXI_BVALID_OUT,
    input wire logic        AXI_BREADY_IN,
    input wire logic        AXI_ARVALID_IN,
    input wire logic        AXI_ARREADY_OUT,
    input wire logic        AXI_RVALID_OUT,
    input wire logic        AXI_RREADY_IN,
    input wire logic [31:0] AXI_RDATA_OUT,
    // Interrupt requests
    input wire logic        IRQ_OUT,
    input wire logic        TX_GROUP_REQ_OUT,
    input wire logic        RX_GROUP_REQ_OUT
);
    //==================================================================
    // Bus and interrupt checks
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (RST_IN);

    logic wr_take;
    assign wr_take = AXI_AWVALID_IN && AXI_AWREADY_OUT
                  && AXI_WVALID_IN && AXI_WREADY_OUT;

    a_write_answer: assert property (wr_take |-> ##[1:2] AXI_BVALID_OUT)
        else $error("write answer missing");
    a_write_busy: assert property (wr_take |=>
        !AXI_AWREADY_OUT && !AXI_WREADY_OUT)
        else $error("write ready not dropped");
    a_bvalid_hold: assert property (AXI_BVALID_OUT && !AXI_BREADY_IN
        |=> AXI_BVALID_OUT) else $error("write answer dropped");
    a_read_answer: assert property (AXI_ARVALID_IN && AXI_ARREADY_OUT
        |=> AXI_RVALID_OUT) else $error("read answer missing");
    a_read_hold: assert property (AXI_RVALID_OUT && !AXI_RREADY_IN
        |=> AXI_RVALID_OUT && $stable(AXI_RDATA_OUT))
        else $error("read answer not held");
    a_read_busy: assert property (AXI_RVALID_OUT |-> !AXI_ARREADY_OUT)
        else $error("read ready while answer pending");
    a_rdata_upper: assert property (AXI_RVALID_OUT |->
        AXI_RDATA_OUT[31:8] == 24'h000000) else $error("upper data set");
    a_reset_quiet: assert property ($fell(RST_IN) |->
        !IRQ_OUT && !TX_GROUP_REQ_OUT && !RX_GROUP_REQ_OUT)
        else $error("request after reset");
endmodule : cbie_chk

bind cbie_top cbie_chk cbie_chk_inst (
    .CLK_SYS_IN      (CLK_SYS_IN),
    .RST_IN          (RST_IN),
    .AXI_AWVALID_IN  (AXI_AWVALID_IN),
    .AXI_AWREADY_OUT (AXI_AWREADY_OUT),
    .AXI_WVALID_IN   (AXI_WVALID_IN),
    .AXI_WREADY_OUT  (AXI_WREADY_OUT),
    .AXI_BVALID_OUT  (AXI_BVALID_OUT),
    .AXI_BREADY_IN   (AXI_BREADY_IN),
    .AXI_ARVALID_IN  (AXI_ARVALID_IN),
    .AXI_ARREADY_OUT (AXI_ARREADY_OUT),
    .AXI_RVALID_OUT  (AXI_RVALID_OUT),
    .AXI_RREADY_IN   (AXI_RREADY_IN),
    .AXI_RDATA_OUT   (AXI_RDATA_OUT),
    .IRQ_OUT         (IRQ_OUT),
    .TX_GROUP_REQ_OUT(TX_GROUP_REQ_OUT),
    .RX_GROUP_REQ_OUT(RX_GROUP_REQ_OUT)
);

`default_nettype wire

// File: cbie_top_tb.sv
`default_nettype none

`define CHK(g, e) \
    begin \
        check_count++; \
        if ((g) !== (e)) \
        begin \
            fails++; \
            $display("[ERR] %0t got %h want %h", $time, g, e); \
        end \
    end

module cbie_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    //==================================================================
    // Signals
    localparam logic [11:0] ITX = cbie_pkg::IDX_TX_BUF_EN;
    localparam logic [11:0] IBE = cbie_pkg::IDX_BUF_EN_LOW;
    localparam logic [11:0] IST = cbie_pkg::IDX_CTRL_STATUS;
    localparam logic [11:0] IFL = cbie_pkg::IDX_PERIPH_FLAGS;
    localparam logic [11:0] IEN = cbie_pkg::IDX_PERIPH_EN;
    localparam logic [11:0] IMD = cbie_pkg::IDX_MODE_CTRL;
    logic        clk, rst, awv, wv, bry, arv, rry, fwm, inv, wak, ber;
    logic        awr, wr, bv, arr, rv, irq, txq, rxq;
    logic [13:0] awa, ara;
    logic [31:0] wd, rdat;
    logic [3:0]  ws;
    logic [2:0]  txd;
    logic [5:0]  pgd, pgt;
    logic [1:0]  rxd, br, rr;
    logic [7:0]  sts;
    int          fails = 0;
    int          check_count = 0;

    cbie_top cbie_top_inst (
        .CLK_SYS_IN(clk), .RST_IN(rst),
        .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awr), .AXI_AWADDR_IN(awa),
        .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wr), .AXI_WDATA_IN(wd),
        .AXI_WSTRB_IN(ws), .AXI_BVALID_OUT(bv), .AXI_BREADY_IN(bry),
        .AXI_BRESP_OUT(br), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arr),
        .AXI_ARADDR_IN(ara), .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rry),
        .AXI_RDATA_OUT(rdat), .AXI_RRESP_OUT(rr), .TX_DONE_IN(txd),
        .PROG_DONE_IN(pgd), .PROG_IS_TX_IN(pgt), .RX_DONE_IN(rxd),
        .FIFO_WM_IN(fwm), .INVALID_MSG_IN(inv), .WAKE_IN(wak),
        .BUS_ERROR_IN(ber), .CTRL_STATUS_IN(sts), .IRQ_OUT(irq),
        .TX_GROUP_REQ_OUT(txq), .RX_GROUP_REQ_OUT(rxq)
    );

    //==================================================================
    // Bus and event tasks
    task automatic bus_wr(input logic [11:0] i, input logic [7:0] d,
                          input logic [3:0] s = 4'hF);
        awa <= {i, 2'b00};
        wd <= {24'h000000, d};
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
            if (bv && !bry) bry <= 1'b1;
        end
        while (!(bry && bv));
        bry <= 1'b0;
        `CHK(br, cbie_pkg::RESP_OK);
    endtask : bus_wr

    task automatic chk_rd(input logic [11:0] i, input logic [7:0] e);
        logic [31:0] d;
        ara <= {i, 2'b00};
        arv <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
            if (rv && !rry) rry <= 1'b1;
        end
        while (!(rry && rv));
        d = rdat;
        rry <= 1'b0;
        `CHK(d, {24'h000000, e});
        `CHK(rr, cbie_pkg::RESP_OK);
    endtask : chk_rd

    task automatic ev(input logic [2:0] t, input logic [5:0] p,
                      input logic [1:0] r, input logic [2:0] m);
        txd <= t;
        pgd <= p;
        rxd <= r;
        {inv, wak, ber} <= m;
        @(posedge clk);
        txd <= 3'h0;
        pgd <= 6'h00;
        rxd <= 2'h0;
        {inv, wak, ber} <= 3'h0;
        repeat (2) @(posedge clk);
    endtask : ev

    task automatic clr;
        bus_wr(IFL, 8'hFF);
        @(posedge clk);
        `CHK(irq, 1'b0);
    endtask : clr

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    //==================================================================
    // Scenarios
    task automatic t_reset;
        chk_rd(ITX, 8'h00);
        chk_rd(IBE, 8'h00);
        chk_rd(12'h123, 8'h00);
        $display("test reset finished");
    endtask : t_reset

    task automatic t_regs;
        bus_wr(IMD, 8'h01);
        bus_wr(ITX, 8'hFF);
        chk_rd(ITX, 8'h1C);
        bus_wr(ITX, 8'h00, 4'hE);
        chk_rd(ITX, 8'h1C);
        bus_wr(IBE, 8'hFF);
        chk_rd(IBE, 8'hFF);
        bus_wr(IBE, 8'h00);
        chk_rd(IBE, 8'h00);
        bus_wr(12'h123, 8'hFF);
        chk_rd(12'h123, 8'h00);
        $display("test registers finished");
    endtask : t_regs

    task automatic t_mirror;
        sts <= 8'hA5;
        @(posedge clk);
        chk_rd(IST, 8'hA5);
        for (int k = 0; k < cbie_pkg::N_MIRROR; k++)
            chk_rd(cbie_pkg::IDX_STATUS_MIRROR[k], 8'hA5);
        bus_wr(cbie_pkg::IDX_STATUS_MIRROR[1], 8'h00);
        chk_rd(cbie_pkg::IDX_STATUS_MIRROR[1], 8'hA5);
        $display("test mirror finished");
    endtask : t_mirror

    task automatic t_tx;
        bus_wr(ITX, 8'h08);
        bus_wr(IEN, 8'h10);
        ev(3'b001, 6'h00, 2'h0, 3'h0);
        `CHK(irq, 1'b0);
        chk_rd(IFL, 8'h00);
        ev(3'b010, 6'h00, 2'h0, 3'h0);
        `CHK(irq, 1'b1);
        `CHK(txq, 1'b1);
        chk_rd(IFL, 8'h10);
        clr();
        bus_wr(IEN, 8'h00);
        ev(3'b010, 6'h00, 2'h0, 3'h0);
        `CHK(irq, 1'b0);
        `CHK(txq, 1'b0);
        clr();
        $display("test transmit finished");
    endtask : t_tx

    task automatic t_rx;
        bus_wr(IBE, 8'h05);
        bus_wr(IEN, 8'h02);
        ev(3'h0, 6'h00, 2'b10, 3'h0);
        `CHK(irq, 1'b0);
        ev(3'h0, 6'h00, 2'b01, 3'h0);
        `CHK(irq, 1'b1);
        `CHK(rxq, 1'b1);
        chk_rd(IFL, 8'h02);
        clr();
        ev(3'h0, 6'h01, 2'h0, 3'h0);
        `CHK(irq, 1'b1);
        clr();
        pgt <= 6'h01;
        bus_wr(IEN, 8'h10);
        ev(3'h0, 6'h01, 2'h0, 3'h0);
        chk_rd(IFL, 8'h10);
        `CHK(txq, 1'b1);
        clr();
        bus_wr(IEN, 8'h00);
        ev(3'h0, 6'h00, 2'b01, 3'h0);
        `CHK(irq, 1'b0);
        clr();
        $display("test receive finished");
    endtask : t_rx

    task automatic t_legacy;
        bus_wr(IMD, 8'h00);
        bus_wr(ITX, 8'h00);
        bus_wr(IEN, 8'h10);
        ev(3'b100, 6'h00, 2'h0, 3'h0);
        `CHK(irq, 1'b1);
        chk_rd(IFL, 8'h10);
        clr();
        ev(3'b011, 6'h00, 2'b11, 3'b111);
        `CHK(irq, 1'b0);
        chk_rd(IFL, 8'hEF);
        clr();
        $display("test legacy finished");
    endtask : t_legacy

    task automatic t_fifo;
        bus_wr(IMD, 8'h02);
        bus_wr(IMD, 8'h03);
        chk_rd(IMD, 8'h02);
        bus_wr(IEN, 8'h01);
        fwm <= 1'b1;
        @(posedge clk);
        fwm <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1);
        chk_rd(IFL, 8'h01);
        clr();
        $display("test fifo finished");
    endtask : t_fifo

    //==================================================================
    // Clock, reset, sequence and watchdog
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial
    begin
        {rst, awv, wv, bry, arv, rry} = 6'h20;
        {fwm, inv, wak, ber} = 4'h0;
        {awa, ara, wd, ws, sts} = '0;
        {txd, pgd, pgt, rxd} = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_regs();
        t_mirror();
        t_tx();
        t_rx();
        t_legacy();
        t_fifo();
        finish_test();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        finish_test();
    end
endmodule : cbie_top_tb

`default_nettype wire
